//--- logic/video_clamp_control.v
// Purpose: clamp window and per-channel clamp control for a digitizer
// Assumes: 50 MHz clk, plain register port, pins from another domain
// Notes: gain registers stored only; they never touch clamp level
//
// Decided for this implementation: strobed register access and the address map.
`include "video_clamp_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module video_clamp_control #(
    parameter CW = 12
) (
    input wire clk, // master clock
    input wire rst_b, // chip reset, active low
    input wire [3:0] addr, // register index
    input wire [15:0] wdata, // write data
    input wire wr, // write strobe
    input wire rd, // read strobe
    output reg [15:0] rdata_q, // read data, cycle after rd
    input wire line_sync_in, // line sync pin
    input wire external_clamp_pulse, // external clamp pin
    output reg [23:0] clamp_level_q, // three blanking targets
    output reg [2:0] clamp_on_q, // per-channel clamp enable
    output reg slicer_clamp_q, // slicer input clamp enable
    output reg slicer_sel_q, // slicer source is dedicated input
    output reg sync_out_en_q // composite sync output enable
);
    // ************************************************************
    // reset and pin synchronisers
    // ************************************************************
    reg rst_s1_q, rst_s2_q;
    wire rst_i = rst_s2_q;
    reg [1:0] hs_sync_q, ext_sync_q;
    reg hs_prev_q;

    // caught asynchronously, released on clock
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    always @(posedge clk or negedge rst_i)
    begin
        if (!rst_i)
        begin
            hs_sync_q <= 2'b00;
            ext_sync_q <= 2'b00;
        end
        else
        begin
            hs_sync_q <= {hs_sync_q[0], line_sync_in};
            ext_sync_q <= {ext_sync_q[0], external_clamp_pulse};
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    reg [7:0] ctrl_q;
    reg [CW-1:0] start_q, width_q;
    reg [7:0] code_q [0:2];
    reg [7:0] gain_q [0:2];
    reg [2:0] seen_q;
    integer i;

    wire pol = ctrl_q[`CTRL_SYNC_POL];
    wire hs_act = hs_sync_q[1] ^ pol;
    wire hs_edge = hs_act & ~hs_prev_q;
    wire ext_win = ext_sync_q[1];
    wire int_win;

    always @(posedge clk or negedge rst_i)
    begin
        if (!rst_i)
        begin
            ctrl_q <= `CTRL_RESET;
            start_q <= `START_RESET;
            width_q <= `WIDTH_RESET;
            for (i = 0; i < 3; i = i + 1)
            begin
                code_q[i] <= `CODE_RESET;
                gain_q[i] <= `GAIN_RESET;
            end
        end
        else if (wr)
        begin
            case (addr)
                `ADDR_CTRL: ctrl_q <= wdata[7:0];
                `ADDR_START: start_q <= wdata[CW-1:0];
                `ADDR_WIDTH: width_q <= wdata[CW-1:0];
                `ADDR_CODE0: code_q[0] <= wdata[7:0];
                `ADDR_CODE1: code_q[1] <= wdata[7:0];
                `ADDR_CODE2: code_q[2] <= wdata[7:0];
                `ADDR_GAIN0: gain_q[0] <= wdata[7:0];
                `ADDR_GAIN1: gain_q[1] <= wdata[7:0];
                `ADDR_GAIN2: gain_q[2] <= wdata[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // clamp window
    // ************************************************************
    clamp_window_gen #(.CW(CW)) u_win (
        .clk(clk),
        .rst_b(rst_i),
        .sync_edge(hs_edge),
        .start_cnt(start_q),
        .width_cnt(width_q),
        .window_q(int_win)
    );

    // window must sit on a porch; software places it there
    wire win = ctrl_q[`CTRL_EN] &
        (ctrl_q[`CTRL_EXT_SEL] ? ext_win : int_win);

    wire [23:0] lvl;
    wire [2:0] on;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : ch
            clamp_channel u_ch (
                .clk(clk),
                .rst_b(rst_i),
                .clamp_code(code_q[g]),
                .mid_level(ctrl_q[`CTRL_MID_CH1 + g]),
                .window(win),
                .level_q(lvl[8*g +: 8]),
                .clamp_on_q(on[g])
            );
        end
    endgenerate

    // ************************************************************
    // outputs and status
    // ************************************************************
    always @(posedge clk or negedge rst_i)
    begin
        if (!rst_i)
        begin
            hs_prev_q <= 1'b0;
            clamp_level_q <= 24'h00_0000;
            clamp_on_q <= 3'b000;
            slicer_clamp_q <= 1'b0;
            slicer_sel_q <= 1'b0;
            sync_out_en_q <= 1'b0;
            seen_q <= 3'b000;
        end
        else
        begin
            hs_prev_q <= hs_act;
            clamp_level_q <= lvl;
            clamp_on_q <= on;
            slicer_sel_q <= ctrl_q[`CTRL_SLICE_SEL];
            slicer_clamp_q <= ctrl_q[`CTRL_SLICE_SEL] & on[0];
            sync_out_en_q <= ~ctrl_q[`CTRL_MID_CH1];
            // sticky seen bits: set wins over read clear
            seen_q <= ((rd && addr == `ADDR_STATUS) ? 3'b000 : seen_q)
                | {hs_edge, ext_win, win};
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    always @(posedge clk or negedge rst_i)
    begin
        if (!rst_i)
            rdata_q <= 16'h0000;
        else if (rd)
        begin
            case (addr)
                `ADDR_CTRL: rdata_q <= {8'h00, ctrl_q};
                `ADDR_START: rdata_q <= {{(16-CW){1'b0}}, start_q};
                `ADDR_WIDTH: rdata_q <= {{(16-CW){1'b0}}, width_q};
                `ADDR_CODE0: rdata_q <= {8'h00, code_q[0]};
                `ADDR_CODE1: rdata_q <= {8'h00, code_q[1]};
                `ADDR_CODE2: rdata_q <= {8'h00, code_q[2]};
                `ADDR_GAIN0: rdata_q <= {8'h00, gain_q[0]};
                `ADDR_GAIN1: rdata_q <= {8'h00, gain_q[1]};
                `ADDR_GAIN2: rdata_q <= {8'h00, gain_q[2]};
                `ADDR_STATUS: rdata_q <= {10'h000, hs_act, win,
                    1'b0, seen_q};
                default: rdata_q <= 16'h0000;
            endcase
        end
        else
            rdata_q <= 16'h0000;
    end
endmodule // video_clamp_control
`default_nettype wire

//--- logic/video_clamp_defs.vh
// Purpose: constants for the video clamp control block
// Assumes: 50 MHz clk, register port with read data one cycle later
// Notes: offsets are word indexes on the plain register port
`ifndef VIDEO_CLAMP_DEFS_VH
`define VIDEO_CLAMP_DEFS_VH

`define ADDR_CTRL 4'h0
`define ADDR_START 4'h1
`define ADDR_WIDTH 4'h2
`define ADDR_CODE0 4'h3
`define ADDR_CODE1 4'h4
`define ADDR_CODE2 4'h5
`define ADDR_GAIN0 4'h6
`define ADDR_GAIN1 4'h7
`define ADDR_GAIN2 4'h8
`define ADDR_STATUS 4'h9

`define CTRL_EXT_SEL 0
`define CTRL_SYNC_POL 1
`define CTRL_MID_CH1 2
`define CTRL_MID_CH2 3
`define CTRL_MID_CH3 4
`define CTRL_SLICE_SEL 5
`define CTRL_EN 6

`define CTRL_RESET 8'h0040
`define START_RESET 12'h0010
`define WIDTH_RESET 12'h0020
`define CODE_RESET 8'h0080
`define GAIN_RESET 8'h0000
`define MID_SCALE 8'h0080

`endif

//--- logic/clamp_window_gen.v
// Purpose: internal clamp window timed from active line sync edge
// Assumes: sync already synchronised and polarity corrected
// Notes: a new edge restarts the delay
`timescale 1ns/100ps
`default_nettype none
module clamp_window_gen #(
    parameter CW = 12
) (
    input wire clk, // clock
    input wire rst_b, // synced reset, active low
    input wire sync_edge, // active sync edge pulse
    input wire [CW-1:0] start_cnt, // clocks from edge to window
    input wire [CW-1:0] width_cnt, // window length in clocks
    output reg window_q // internal clamp window
);
    reg [CW-1:0] cnt_q;
    reg delay_q;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= {CW{1'b0}};
            delay_q <= 1'b0;
            window_q <= 1'b0;
        end
        else if (sync_edge)
        begin
            cnt_q <= start_cnt;
            delay_q <= 1'b1;
            window_q <= 1'b0;
        end
        else if (delay_q)
        begin
            if (cnt_q == {CW{1'b0}})
            begin
                delay_q <= 1'b0;
                window_q <= (width_cnt != {CW{1'b0}});
                cnt_q <= width_cnt - {{(CW-1){1'b0}}, 1'b1};
            end
            else
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
        else if (window_q)
        begin
            if (cnt_q == {CW{1'b0}})
                window_q <= 1'b0;
            else
                cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // clamp_window_gen
`default_nettype wire

//--- logic/clamp_channel.v
// Purpose: one channel's clamp level target and clamp enable
// Assumes: code and mode held by top registers
// Notes: level is the converter code that blanking maps to
`timescale 1ns/100ps
`default_nettype none
module clamp_channel (
    input wire clk, // clock
    input wire rst_b, // synced reset, active low
    input wire [7:0] clamp_code, // programmed clamp code
    input wire mid_level, // centre on mid-scale
    input wire window, // clamp window
    output reg [7:0] level_q, // blanking target code
    output reg clamp_on_q // clamp enable
);
    // offset is code/2 - 64, range -64 to +63, spans 128 codes
    wire signed [9:0] offs = $signed({2'b00, clamp_code[7:1]}) - 10'sd64;
    wire signed [9:0] base = mid_level ? 10'sd128 : 10'sd0;
    wire signed [9:0] sum = base + offs;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            level_q <= 8'h00;
            clamp_on_q <= 1'b0;
        end
        else
        begin
            if (sum < 10'sd0)
                level_q <= 8'h00;
            else
                level_q <= sum[7:0];
            clamp_on_q <= window;
        end
    end
endmodule // clamp_channel
`default_nettype wire

//--- testbench/line_source.sv
// Purpose: far side model, line sync and external clamp pulse
// Assumes: the bench starts lines with run
// Notes: outputs sit inactive outside lines
`timescale 1ns/100ps
`default_nettype none
module line_source (
    input wire logic clk, // clock
    input wire logic run, // emit lines
    input wire logic pol_low, // sync active low
    output wire logic line_sync_in, // line sync
    output wire logic external_clamp_pulse // clamp pulse
);
    logic [5:0] cnt_q;
    always @(posedge clk)
        cnt_q <= run ? cnt_q + 6'h01 : 6'h00;
    assign line_sync_in = pol_low ^ (run && cnt_q < 6'h06);
    // pulse sits on the back porch, active high
    assign external_clamp_pulse = run && cnt_q >= 6'h0a &&
        cnt_q < 6'h11;
endmodule // line_source
`default_nettype wire

//--- testbench/video_clamp_control_asserts.sv
// Purpose: port checks for the clamp control block
// Assumes: bound to the top module
// Notes: quiet means no write for five clocks
`timescale 1ns/100ps
`default_nettype none
`include "video_clamp_defs.vh"
module video_clamp_control_asserts (
    input wire logic clk, // clock
    input wire logic rst_b, // reset
    input wire logic [3:0] addr, // index
    input wire logic [15:0] wdata, // data
    input wire logic wr, // write
    input wire logic rd, // read
    input wire logic [15:0] rdata_q, // read data
    input wire logic external_clamp_pulse, // pin
    input wire logic [23:0] clamp_level_q, // levels
    input wire logic [2:0] clamp_on_q, // enables
    input wire logic slicer_sel_q, // slicer source
    input wire logic sync_out_en_q // sync out
);
    logic [7:0] ctrl_m;
    logic [11:0] wid_m;
    logic [11:0] run_q;
    logic [2:0] q_q;
    logic rise_ok_q;
    wire logic quiet = (q_q == 3'h5);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_m <= 8'h40;
            wid_m <= 12'h020;
            q_q <= 3'h0;
            run_q <= 12'h000;
            rise_ok_q <= 1'b0;
        end
        else
        begin
            if (wr && addr == `ADDR_CTRL)
                ctrl_m <= wdata[7:0];
            if (wr && addr == `ADDR_WIDTH)
                wid_m <= wdata[11:0];
            q_q <= wr ? 3'h0 : (quiet ? q_q : q_q + 3'h1);
            run_q <= clamp_on_q[0] ? run_q + 12'h001 : 12'h000;
            // width judged only for windows opened while quiet
            if (clamp_on_q[0] && run_q == 12'h000)
                rise_ok_q <= quiet && !ctrl_m[0];
        end
    end
    a_read_idle:
    assert property (!$past(rd) |-> rdata_q == 16'h0000)
        else $error("read data outside its slot");
    a_off_no_clamp:
    assert property (quiet && !ctrl_m[6] |-> clamp_on_q == 3'h0)
        else $error("clamp while disabled");
    a_ext_follow:
    assert property (quiet && ctrl_m[6] && ctrl_m[0] &&
        $rose(external_clamp_pulse) |-> ##[3:4] clamp_on_q == 3'h7)
        else $error("external pulse not followed");
    a_int_width:
    assert property (quiet && rise_ok_q && !ctrl_m[0] &&
        $fell(clamp_on_q[0]) |-> run_q == wid_m)
        else $error("internal window width wrong");
    a_mid_sync_off:
    assert property (quiet |-> sync_out_en_q == !ctrl_m[2])
        else $error("sync output enable wrong");
    a_slicer_sel:
    assert property (quiet |-> slicer_sel_q == ctrl_m[5])
        else $error("slicer source wrong");
    a_bottom_level:
    assert property (quiet && !ctrl_m[2] |-> clamp_level_q[7:0] <= 8'h3f)
        else $error("bottom level out of range");
    a_mid_level:
    assert property (quiet && ctrl_m[2] |-> clamp_level_q[7:0] >= 8'h40)
        else $error("mid level out of range");
    c_ext: cover property (ctrl_m[0] && clamp_on_q == 3'h7);
    c_int: cover property (!ctrl_m[0] && clamp_on_q[0]);
    c_mid: cover property (quiet && !sync_out_en_q);
endmodule // video_clamp_control_asserts
bind video_clamp_control video_clamp_control_asserts i_asserts (.clk,
    .rst_b, .addr, .wdata, .wr, .rd, .rdata_q, .external_clamp_pulse,
    .clamp_level_q, .clamp_on_q, .slicer_sel_q, .sync_out_en_q);
`default_nettype wire

//--- testbench/video_clamp_control_test.sv
// Purpose: self-checking bench for the clamp control block
// Assumes: line_source drives the pins
// Notes: start delay judged as a difference
`timescale 1ns/100ps
`default_nettype none
`include "video_clamp_defs.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); \
    err_count++; end end
module video_clamp_control_test;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic run = 1'b0, pol_low = 1'b0, sl;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, v;
    logic [2:0] hi;
    wire [15:0] rdata_q;
    wire [23:0] lvl;
    wire [2:0] con;
    wire ls, ext, sc, ss, soe;
    int err_count = 0, cmp_count = 0, cyc = 0, d, w, d1, i, k;
    always #10 clk = ~clk;
    video_clamp_control i_video_clamp_control (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .line_sync_in(ls), .external_clamp_pulse(ext),
        .clamp_level_q(lvl), .clamp_on_q(con), .slicer_clamp_q(sc),
        .slicer_sel_q(ss), .sync_out_en_q(soe));
    line_source i_line_source (.clk(clk), .run(run), .pol_low(pol_low),
        .line_sync_in(ls), .external_clamp_pulse(ext));
    function automatic logic [7:0] lv(logic [7:0] c, logic m);
        int x;
        x = (m ? 64 : -64) + int'(c) / 2;
        return x < 0 ? 8'h00 : 8'(x);
    endfunction
    task wreg(input logic [3:0] a, input logic [15:0] dv);
    begin
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rreg(input logic [3:0] a, output logic [15:0] rv);
    begin
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        rv = rdata_q;
    end
    endtask
    // one line: delay to window, window width, slicer seen
    task meas;
    begin
        d = 0;
        w = 0;
        sl = 1'b0;
        repeat (70) @(posedge clk);
        run <= 1'b1;
        @(negedge clk);
        while (con[0] !== 1'b1 && d < 60)
        begin
            @(negedge clk);
            d++;
        end
        hi = con;
        while (con[0] === 1'b1 && w < 60)
        begin
            sl = sl | sc;
            @(negedge clk);
            w++;
        end
        @(posedge clk);
        run <= 1'b0;
    end
    endtask
    task t_reset;
    begin
        `CHK("sync out", 1'b1, soe)
        for (i = 0; i < 10; i++)
        begin
            rreg(i == 9 ? 4'hf : 4'(i), v);
            `CHK("reset", i == 0 ? 16'h0040 : i < 3 ? 16'h0010 * i :
                i < 6 ? 16'h0080 : 16'h0000, v)
        end
    end
    endtask
    task t_regs;
    begin
        for (i = 3; i < 9; i++)
            wreg(4'(i), 16'(16'h0011 * i));
        wreg(4'hf, 16'hffff);
        for (i = 3; i < 9; i++)
        begin
            rreg(4'(i), v);
            `CHK("reg back", 16'(16'h0011 * i), v)
        end
        rreg(4'hf, v);
        `CHK("unmapped", 16'h0000, v)
    end
    endtask
    task t_level;
        logic [7:0] c;
        logic [2:0] m;
        logic [23:0] e;
    begin
        for (k = 0; k < 10; k++)
        begin
            m = k[0] ? 3'b001 : 3'b110;
            c = 8'(k * 28);
            wreg(`ADDR_CTRL, {9'h000, 1'b1, 1'b0, m, 2'b00});
            wreg(`ADDR_CODE0, {8'h00, c});
            wreg(`ADDR_CODE1, {8'h00, ~c});
            wreg(`ADDR_CODE2, {8'h00, c + 8'h02});
            repeat (4) @(posedge clk);
            e = {lv(c + 8'h02, m[2]), lv(~c, m[1]), lv(c, m[0])};
            `CHK("level", e, lvl)
            `CHK("sync out", !m[0], soe)
        end
    end
    endtask
    task t_ext;
    begin
        wreg(`ADDR_CTRL, 16'h0061);
        meas;
        `CHK("ext width", 7, w)
        `CHK("ext all", 3'h7, hi)
        `CHK("slicer clamp", 1'b1, sl)
        `CHK("slicer sel", 1'b1, ss)
        rreg(`ADDR_STATUS, v);
        `CHK("status seen", 16'h0007, v)
        rreg(`ADDR_STATUS, v);
        `CHK("status clear", 16'h0000, v)
    end
    endtask
    task t_int;
    begin
        wreg(`ADDR_START, 16'h0004);
        wreg(`ADDR_WIDTH, 16'h0005);
        wreg(`ADDR_CTRL, 16'h0040);
        meas;
        d1 = d;
        `CHK("int width", 5, w)
        pol_low <= 1'b1;
        wreg(`ADDR_CTRL, 16'h0042);
        wreg(`ADDR_START, 16'h0009);
        meas;
        `CHK("int start", 5, d - d1)
        `CHK("int width", 5, w)
    end
    endtask
    task t_off;
    begin
        wreg(`ADDR_CTRL, 16'h0000);
        meas;
        `CHK("no clamp", 0, w)
    end
    endtask
    task end_sim;
    begin
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_count++;
            end_sim;
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset;
        t_regs;
        t_level;
        t_ext;
        t_int;
        t_off;
        end_sim;
    end
endmodule // video_clamp_control_test
`default_nettype wire
